//--- hdl/touch_power_filter.sv
// Power-save sequencing, oversampling, delta and focus filtering, report framing
module touch_power_filter #(
  parameter int IDLE_CYCLES = touch_pkg::IDLE_CYCLES,
  parameter int FIFO_DEPTH = touch_pkg::FIFO_DEPTH
) (
  input wire logic core_clk, // 10 MHz core clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic touch_pin, // Panel touch detect, asynchronous
  input wire logic standby_req_n_pin, // Standby request pin, low holds standby
  input wire logic rx_line_pin, // Raw serial receive line, idle high
  input wire logic rx_valid, // Received byte strobe from the UART
  input wire logic [7:0] rx_byte, // Received byte
  input wire logic raw_valid, // One raw conversion of all axes
  input wire touch_pkg::coord_type raw_sample, // Raw conversion values
  input wire touch_pkg::cfg_type cfg, // Sample count, max delta, focus, pressure
  input wire logic out_ready, // Transmitter takes a byte
  output logic out_valid, // Byte waiting for the transmitter
  output logic [7:0] out_byte, // Byte to transmit
  output logic flush_pulse, // Clears the UART receive and transmit buffers
  output logic osc_run, // Oscillator enable, low in standby
  output logic led_out, // Indicator, high in standby
  output logic spd_enabled // Self power-down enable state
);
  typedef enum logic [2:0] {PS_RUN, PS_SELF, PS_CMD, PS_PIN, PS_FLUSH} pstate_type;
  localparam int CW = touch_pkg::COORD_W;
  localparam int SW = touch_pkg::ACC_W;

  pstate_type state_reg, state_next;
  logic [2:0] meta_reg, sync_reg;
  logic touch, sb_n, rx_act;
  logic spd_reg, shut_pend_reg, ack_pend_reg, ack_value_reg;
  logic [31:0] idle_reg;
  logic osc_reg, led_reg, flush_reg;
  logic run, cmd_ok, shut_go, idle_done;
  logic [2:0] shift;
  logic [5:0] smp_cnt_reg;
  logic [touch_pkg::ACC_W-1:0] acc_reg [3];
  logic [touch_pkg::ACC_W-1:0] sum [3];
  logic avg_valid_reg, rep_valid_reg;
  touch_pkg::coord_type avg_reg, rep_reg;
  logic [1:0] hist_reg;
  logic [CW-1:0] h1_reg [2], h2_reg [2], ref_reg [2];
  logic [1:0] near_ok, far;
  logic accept, refocus;
  logic [7:0] msg_reg [touch_pkg::MSG_MAX];
  logic [2:0] len_reg, idx_reg;
  logic busy, load_ack, load_rep, fifo_in_ready, fifo_empty;

  // Pins are two-flop synchronised; only sync_reg feeds logic
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_reg <= touch_pkg::SYNC_RESET;
      sync_reg <= touch_pkg::SYNC_RESET;
    end else begin
      meta_reg <= {touch_pin, standby_req_n_pin, rx_line_pin};
      sync_reg <= meta_reg;
    end
  end
  assign touch = sync_reg[2];
  assign sb_n = sync_reg[1];
  assign rx_act = !sync_reg[0];

  assign run = state_reg == PS_RUN;
  assign cmd_ok = run && sb_n && rx_valid;
  // Shutdown waits for its acknowledge to leave before the clock is stopped
  assign shut_go = shut_pend_reg && !busy && !ack_pend_reg && fifo_empty;
  assign idle_done = spd_reg && (idle_reg >= 32'(IDLE_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    if (!sb_n) begin
      state_next = PS_PIN;
    end else begin
      unique case (state_reg)
        PS_RUN: begin
          if (shut_go) begin
            state_next = PS_CMD;
          end else if (idle_done) begin
            state_next = PS_SELF;
          end
        end
        PS_SELF: begin
          if (touch || rx_act) begin
            state_next = PS_RUN;
          end
        end
        PS_CMD: begin
          if ((rx_valid && rx_byte == touch_pkg::CMD_WAKE) || (spd_reg && touch)) begin
            state_next = PS_FLUSH;
          end
        end
        PS_PIN: state_next = PS_FLUSH;
        PS_FLUSH: state_next = PS_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg <= PS_RUN;
      osc_reg <= 1'b1;
      led_reg <= 1'b0;
      flush_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      osc_reg <= state_next inside {PS_RUN, PS_FLUSH};
      led_reg <= state_next inside {PS_SELF, PS_CMD, PS_PIN};
      flush_reg <= state_next == PS_FLUSH;
    end
  end

  // Inactivity timer; a long default, shorten IDLE_CYCLES in simulation
  always_ff @(posedge core_clk) begin
    if (!reset_n || !run || touch || rx_act || rx_valid) begin
      idle_reg <= '0;
    end else if (!idle_done) begin
      idle_reg <= idle_reg + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      spd_reg <= touch_pkg::DEF_SPD_ENABLE;
      shut_pend_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      ack_value_reg <= 1'b0;
    end else begin
      if (cmd_ok && rx_byte == touch_pkg::CMD_TOGGLE_SPD) begin
        spd_reg <= !spd_reg;
      end
      if (cmd_ok && rx_byte == touch_pkg::CMD_SHUTDOWN) begin
        shut_pend_reg <= 1'b1;
      end else if (!run) begin
        shut_pend_reg <= 1'b0;
      end
      if (cmd_ok && (rx_byte == touch_pkg::CMD_TOGGLE_SPD || rx_byte == touch_pkg::CMD_SHUTDOWN)) begin
        ack_pend_reg <= 1'b1;
        ack_value_reg <= rx_byte == touch_pkg::CMD_TOGGLE_SPD;
      end else if (load_ack || state_reg == PS_FLUSH) begin
        ack_pend_reg <= 1'b0;
      end
    end
  end

  // Oversampling: sum 2^shift conversions, then shift back down
  always_comb begin
    unique case (cfg.samples)
      6'h01: shift = 3'h0;
      6'h02: shift = 3'h1;
      6'h04: shift = 3'h2;
      6'h08: shift = 3'h3;
      6'h10: shift = 3'h4;
      6'h20: shift = 3'h5;
      default: shift = touch_pkg::DEF_SHIFT;
    endcase
  end
  assign sum[0] = acc_reg[0] + SW'(raw_sample.x);
  assign sum[1] = acc_reg[1] + SW'(raw_sample.y);
  assign sum[2] = acc_reg[2] + SW'(raw_sample.z);

  always_ff @(posedge core_clk) begin
    if (!reset_n || !run) begin
      smp_cnt_reg <= '0;
      acc_reg <= '{default: '0};
      avg_valid_reg <= 1'b0;
      avg_reg <= '0;
    end else begin
      avg_valid_reg <= 1'b0;
      if (raw_valid) begin
        if (smp_cnt_reg >= (6'h1 << shift) - 6'h1) begin
          smp_cnt_reg <= '0;
          acc_reg <= '{default: '0};
          avg_valid_reg <= 1'b1;
          avg_reg.x <= CW'(sum[0] >> shift);
          avg_reg.y <= CW'(sum[1] >> shift);
          avg_reg.z <= CW'(sum[2] >> shift);
        end else begin
          smp_cnt_reg <= smp_cnt_reg + 6'h1;
          acc_reg <= sum;
        end
      end
    end
  end

  // Per-axis prediction, delta check, focus comparison and history
  for (genvar a = 0; a < 2; a++) begin : g_axis
    logic signed [CW+2:0] pred, dev, fdev;
    logic [CW-1:0] cur;
    assign cur = (a == 0) ? avg_reg.x : avg_reg.y;
    // Doubling by a shift widens the prediction three bits beyond its CW-bit history operands
    assign pred = $signed({2'b00, h1_reg[a], 1'b0}) - $signed({3'b000, h2_reg[a]});
    assign dev = $signed({3'b000, cur}) - pred;
    assign fdev = $signed({3'b000, cur}) - $signed({3'b000, ref_reg[a]});
    assign near_ok[a] = (hist_reg < 2'h2) || ((dev < 0 ? -dev : dev) <= $signed({7'h0, cfg.max_delta}));
    assign far[a] = (fdev < 0 ? -fdev : fdev) >= $signed({7'h0, cfg.focus});
    always_ff @(posedge core_clk) begin
      if (!reset_n || !run) begin
        h1_reg[a] <= '0;
        h2_reg[a] <= '0;
        ref_reg[a] <= '0;
      end else if (avg_valid_reg) begin
        h1_reg[a] <= cur;
        h2_reg[a] <= h1_reg[a];
        if (accept && refocus) begin
          ref_reg[a] <= cur;
        end
      end
    end
  end
  assign accept = &near_ok;
  assign refocus = (cfg.focus == '0) || (|far);

  always_ff @(posedge core_clk) begin
    if (!reset_n || !run) begin
      hist_reg <= '0;
      rep_valid_reg <= 1'b0;
      rep_reg <= '0;
    end else begin
      rep_valid_reg <= avg_valid_reg && accept;
      if (avg_valid_reg) begin
        hist_reg <= (hist_reg == 2'h2) ? hist_reg : hist_reg + 2'h1;
        rep_reg <= avg_reg;
        if (!refocus) begin
          rep_reg.x <= ref_reg[0];
          rep_reg.y <= ref_reg[1];
        end
      end
    end
  end

  // Message builder; a report that finds the builder busy is dropped, acks wait
  assign busy = idx_reg != len_reg;
  assign load_ack = !busy && ack_pend_reg;
  assign load_rep = !busy && !ack_pend_reg && rep_valid_reg;

  always_ff @(posedge core_clk) begin
    if (!reset_n || state_reg == PS_FLUSH) begin
      len_reg <= '0;
      idx_reg <= '0;
      msg_reg <= '{default: '0};
    end else if (load_ack) begin
      idx_reg <= '0;
      len_reg <= ack_value_reg ? touch_pkg::LEN_ACK_VALUE : touch_pkg::LEN_ACK;
      msg_reg[0] <= touch_pkg::REPLY_ACK;
      msg_reg[1] <= {7'h0, spd_reg};
    end else if (load_rep) begin
      idx_reg <= '0;
      len_reg <= cfg.pressure_en ? touch_pkg::LEN_REPORT_Z : touch_pkg::LEN_REPORT;
      msg_reg[0] <= cfg.pressure_en ? touch_pkg::HDR_PRESSURE : touch_pkg::HDR_NO_PRESSURE;
      msg_reg[1] <= {2'b00, rep_reg.x[touch_pkg::HI_LSB-1:0], rep_reg.y[touch_pkg::HI_LSB-1:0]};
      msg_reg[2] <= {1'b0, rep_reg.x[CW-1:touch_pkg::HI_LSB]};
      msg_reg[3] <= {1'b0, rep_reg.y[CW-1:touch_pkg::HI_LSB]};
      msg_reg[4] <= {1'b0, rep_reg.z[CW-1:touch_pkg::HI_LSB]};
    end else if (busy && fifo_in_ready) begin
      idx_reg <= idx_reg + 3'h1;
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(core_clk),
    .reset_n(reset_n),
    .flush(state_reg == PS_FLUSH),
    .in_valid(busy),
    .in_data(msg_reg[idx_reg]),
    .in_ready(fifo_in_ready),
    .out_valid(out_valid),
    .out_data(out_byte),
    .out_ready(out_ready),
    .empty(fifo_empty)
  );

  assign flush_pulse = flush_reg;
  assign osc_run = osc_reg;
  assign led_out = led_reg;
  assign spd_enabled = spd_reg;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_pin_holds_standby: assert property (!sb_n |=> state_reg == PS_PIN && led_out)
    else $error("standby pin low but not in pin standby");
  a_pin_release_flush: assert property (state_reg == PS_PIN && sb_n |=> flush_pulse ##1 state_reg == PS_RUN)
    else $error("pin release did not flush then run");
  a_toggle_flips: assert property (cmd_ok && rx_byte == touch_pkg::CMD_TOGGLE_SPD |=> spd_reg != $past(spd_reg))
    else $error("toggle command did not flip self power-down");
  a_standby_pins: assert property (led_out == !osc_run && led_out == (state_reg inside {PS_SELF, PS_CMD, PS_PIN}))
    else $error("indicator or oscillator wrong for state");
  a_idle_entry: assert property (run && sb_n && idle_done && !shut_go |=> state_reg == PS_SELF)
    else $error("idle timeout did not enter standby");
  a_self_wake: assert property (state_reg == PS_SELF && sb_n && (touch || rx_act) |=> run)
    else $error("self standby missed wake event");
  a_cmd_touch_wake: assert property (state_reg == PS_CMD && sb_n && spd_reg && touch |=> state_reg == PS_FLUSH)
    else $error("touch did not wake commanded standby");
  a_cmd_no_touch: assert property (state_reg == PS_CMD && sb_n && !spd_reg && !rx_valid |=> state_reg == PS_CMD)
    else $error("commanded standby left without wake byte");
  a_cmd_wake_flush: assert property (state_reg == PS_CMD && sb_n |=> state_reg != PS_RUN)
    else $error("commanded wake skipped flush");
  a_shutdown_entry: assert property (shut_go && sb_n |=> state_reg == PS_CMD ##1 !osc_run)
    else $error("shutdown did not enter standby");
  a_delta_gate: assert property (avg_valid_reg && run |=> rep_valid_reg == $past(accept))
    else $error("delta gate passed wrong sample");
  a_report_frame: assert property (load_rep && cfg.pressure_en |=> len_reg == touch_pkg::LEN_REPORT_Z
    && msg_reg[4] == {1'b0, $past(rep_reg.z[CW-1:touch_pkg::HI_LSB])})
    else $error("pressure report framing wrong");
  a_toggle_reply: assert property (load_ack && ack_value_reg && state_reg != PS_FLUSH |=>
    msg_reg[0] == touch_pkg::REPLY_ACK && msg_reg[1] == {7'h0, $past(spd_reg)})
    else $error("toggle reply wrong");

  c_self_standby: cover property (run ##1 state_reg == PS_SELF);
  c_cmd_wake: cover property (state_reg == PS_CMD ##1 state_reg == PS_FLUSH ##1 run);
  c_pin_cycle: cover property (state_reg == PS_PIN ##1 flush_pulse);
  c_delta_reject: cover property (avg_valid_reg && !accept);
endmodule // touch_power_filter

//--- hdl/touch_pkg.sv
// Shared constants and carrier types for the touch power-save and coordinate filter block
package touch_pkg;
  localparam int COORD_W = 10;
  localparam int ACC_W = 15;
  localparam logic [7:0] CMD_TOGGLE_SPD = 8'ha2;
  localparam logic [7:0] CMD_WAKE = 8'ha7;
  localparam logic [7:0] CMD_SHUTDOWN = 8'ha8;
  localparam logic [7:0] REPLY_ACK = 8'hca;
  localparam logic [7:0] HDR_PRESSURE = 8'h90;
  localparam logic [7:0] HDR_NO_PRESSURE = 8'h80;
  localparam logic [5:0] DEF_SAMPLES = 6'h08;
  localparam logic [5:0] DEF_MAX_DELTA = 6'h08;
  localparam logic [5:0] DEF_FOCUS = 6'h04;
  localparam logic DEF_SPD_ENABLE = 1'b1;
  localparam logic [2:0] DEF_SHIFT = 3'h3;
  localparam logic [2:0] SYNC_RESET = 3'h3;
  localparam int HI_LSB = 3;
  localparam logic [2:0] LEN_REPORT_Z = 3'h5;
  localparam logic [2:0] LEN_REPORT = 3'h4;
  localparam logic [2:0] LEN_ACK_VALUE = 3'h2;
  localparam logic [2:0] LEN_ACK = 3'h1;
  localparam int MSG_MAX = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 100;
  localparam int IDLE_TIME_US = 10000;
  localparam int IDLE_CYCLES = IDLE_TIME_US * 1000 / CLK_PERIOD_NS;
  typedef struct packed {
    logic [COORD_W-1:0] x;
    logic [COORD_W-1:0] y;
    logic [COORD_W-1:0] z;
  } coord_type;
  typedef struct packed {
    logic [5:0] samples;
    logic [5:0] max_delta;
    logic [5:0] focus;
    logic pressure_en;
  } cfg_type;
endpackage

//--- hdl/byte_fifo.sv
// Byte FIFO with a registered read stage, standing in the serial transmit path
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // Core clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic flush, // Drops all contents
  input wire logic in_valid, // Write request
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic in_ready, // Space available
  output logic out_valid, // Read data present
  output logic [WIDTH-1:0] out_data, // Read data
  input wire logic out_ready, // Reader takes the word
  output logic empty // Nothing stored at all
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic push;
  logic pop;

  assign in_ready = count_reg != CW'(DEPTH);
  assign push = in_valid && in_ready;
  assign pop = (count_reg != '0) && (!out_valid_reg || out_ready);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
  assign empty = (count_reg == '0) && !out_valid_reg;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end

  // Output stage keeps the read data off the memory's combinational path
  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else if (pop) begin
      out_valid_reg <= 1'b1;
      out_data_reg <= mem_reg[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid_reg <= 1'b0;
    end
  end
endmodule // byte_fifo

//--- sim/host_model.sv
// Host driver model: sends command bytes and collects the bytes the block transmits
module host_model #(
  parameter int WAKE_WAIT_CYCLES = 10000 // 1 ms at the 100 ns core clock
) (
  input wire logic core_clk, // Core clock
  input wire logic hold, // Stalls the transmit side
  input wire logic out_valid, // Byte offered by the block
  input wire logic [7:0] out_byte, // Byte offered
  output logic out_ready, // Host takes bytes
  output logic rx_line_pin, // Serial line, idle high
  output logic rx_valid, // Received byte strobe
  output logic [7:0] rx_byte // Received byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  // Stall follows hold directly, which the bench changes only at falling edges
  assign out_ready = !hold;
  initial begin
    rx_line_pin = 1'b1;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  always @(posedge core_clk) if (out_valid === 1'b1 && out_ready) got.push_back(out_byte);
  // Line drops before the byte strobe, as a start bit would
  task automatic send(input logic [7:0] b);
    @(negedge core_clk);
    rx_line_pin = 1'b0;
    repeat (6) @(negedge core_clk);
    rx_valid = 1'b1;
    rx_byte = b;
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_byte = ~b;
    rx_line_pin = 1'b1;
    // Oscillator needs time to restart before any further command
    if (b == touch_pkg::CMD_WAKE) repeat (WAKE_WAIT_CYCLES) @(negedge core_clk);
  endtask
  task automatic poke;
    @(negedge core_clk);
    rx_line_pin = 1'b0;
    repeat (4) @(negedge core_clk);
    rx_line_pin = 1'b1;
  endtask
endmodule // host_model

//--- sim/touch_power_filter_tb.sv
// Self-checking bench for the power-save sequencer and coordinate filter
module touch_power_filter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic touch_pin = 1'b0;
  logic standby_req_n_pin = 1'b1;
  logic raw_valid = 1'b0;
  touch_pkg::coord_type raw_sample = '0;
  touch_pkg::cfg_type cfg = '{samples: 6'h01, max_delta: 6'h08, focus: 6'h00, pressure_en: 1'b1};
  logic hold = 1'b0;
  logic rx_line_pin, rx_valid, out_ready, out_valid, flush_pulse, osc_run, led_out, spd_enabled;
  logic [7:0] rx_byte, out_byte;
  int n_fail = 0;
  int checks_done = 0;
  int n_flush = 0;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (flush_pulse === 1'b1) n_flush++;
  touch_power_filter #(.IDLE_CYCLES(20), .FIFO_DEPTH(8)) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .touch_pin(touch_pin), .standby_req_n_pin(standby_req_n_pin),
    .rx_line_pin(rx_line_pin), .rx_valid(rx_valid), .rx_byte(rx_byte), .raw_valid(raw_valid),
    .raw_sample(raw_sample), .cfg(cfg), .out_ready(out_ready), .out_valid(out_valid), .out_byte(out_byte),
    .flush_pulse(flush_pulse), .osc_run(osc_run), .led_out(led_out), .spd_enabled(spd_enabled));
  host_model i_host (
    .core_clk(core_clk), .hold(hold), .out_valid(out_valid), .out_byte(out_byte), .out_ready(out_ready),
    .rx_line_pin(rx_line_pin), .rx_valid(rx_valid), .rx_byte(rx_byte));
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic expect_byte(input logic [7:0] exp, input string msg);
    logic [7:0] b;
    int i;
    b = 8'hxx;
    for (i = 0; i < 300 && i_host.got.size() == 0; i++) @(negedge core_clk);
    if (i_host.got.size() != 0) b = i_host.got.pop_front();
    checks_done++;
    if (b !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h want %h", $time, msg, b, exp);
    end
  endtask
  task automatic send_raw(input logic [9:0] ax, input logic [9:0] ay, input logic [9:0] az);
    @(negedge core_clk);
    raw_valid = 1'b1;
    raw_sample = '{x: ax, y: ay, z: az};
    @(negedge core_clk);
    raw_valid = 1'b0;
    raw_sample = ~raw_sample;
  endtask
  task automatic expect_report(input logic [9:0] ax, input logic [9:0] ay, input logic [9:0] az);
    expect_byte(cfg.pressure_en ? touch_pkg::HDR_PRESSURE : touch_pkg::HDR_NO_PRESSURE, "header");
    expect_byte({2'b00, ax[2:0], ay[2:0]}, "low bits");
    expect_byte({1'b0, ax[9:3]}, "high x");
    expect_byte({1'b0, ay[9:3]}, "high y");
    if (cfg.pressure_en) expect_byte({1'b0, az[9:3]}, "pressure");
  endtask
  task automatic expect_quiet(input string msg);
    repeat (40) @(negedge core_clk);
    chk_bit(i_host.got.size() == 0, 1'b1, msg);
  endtask
  task automatic wait_led(input logic v, input int n);
    int i;
    for (i = 0; i < n && led_out !== v; i++) @(negedge core_clk);
    // One more edge so a flush pulse launched with the level change is counted
    @(negedge core_clk);
    chk_bit(led_out, v, "indicator level");
    chk_bit(osc_run, !v, "oscillator enable");
  endtask
  task automatic toggle(input logic now_on);
    i_host.send(touch_pkg::CMD_TOGGLE_SPD);
    expect_byte(touch_pkg::REPLY_ACK, "toggle ack");
    expect_byte({7'h00, now_on}, "toggle state");
    chk_bit(spd_enabled, now_on, "self power-down state");
  endtask
  task automatic t_self;
    int f;
    f = n_flush;
    repeat (12) @(negedge core_clk);
    chk_bit(led_out, 1'b0, "slept before idle span");
    wait_led(1'b1, 30);
    touch_pin = 1'b1;
    wait_led(1'b0, 10);
    chk_bit(n_flush == f, 1'b1, "flush on self wake");
    touch_pin = 1'b0;
    wait_led(1'b1, 40);
    i_host.poke();
    wait_led(1'b0, 10);
  endtask
  task automatic t_oversample;
    int k;
    touch_pin = 1'b1;
    repeat (6) @(negedge core_clk);
    for (k = 0; k < 6; k++) begin
      cfg.samples = 6'(1 << k);
      repeat (1 << k) send_raw(10'd100, 10'd50, 10'd80);
      expect_report(10'd100, 10'd50, 10'd80);
    end
    // An unlisted count must average over eight conversions
    cfg.samples = 6'h03;
    for (k = 0; k < 8; k++) send_raw(10'd100 + 10'(k), 10'd50, 10'd80);
    expect_report(10'd103, 10'd50, 10'd80);
    cfg.samples = 6'h04;
    for (k = 0; k < 4; k++) send_raw(10'd100 + 10'(2 * k), 10'd50, 10'd80);
    expect_report(10'd103, 10'd50, 10'd80);
  endtask
  task automatic t_delta;
    cfg.samples = 6'h01;
    send_raw(10'd106, 10'd50, 10'd80);
    expect_report(10'd106, 10'd50, 10'd80);
    send_raw(10'd300, 10'd50, 10'd80);
    expect_quiet("far sample passed");
    send_raw(10'd502, 10'd50, 10'd80);
    expect_report(10'd502, 10'd50, 10'd80);
    send_raw(10'd713, 10'd50, 10'd80);
    expect_quiet("sample beyond max delta passed");
  endtask
  task automatic t_pin;
    int f;
    f = n_flush;
    standby_req_n_pin = 1'b0;
    wait_led(1'b1, 10);
    send_raw(10'd100, 10'd50, 10'd80);
    i_host.send(touch_pkg::CMD_TOGGLE_SPD);
    expect_quiet("activity in pin standby");
    chk_bit(spd_enabled, 1'b1, "command taken in pin standby");
    standby_req_n_pin = 1'b1;
    wait_led(1'b0, 10);
    chk_bit(n_flush == f + 1, 1'b1, "flush on pin release");
  endtask
  // Two reports overfill the 8-word buffer while the host stalls
  task automatic t_fifo;
    hold = 1'b1;
    send_raw(10'd100, 10'd50, 10'd80);
    // A report meeting a busy builder is dropped, so let the first one be loaded
    repeat (10) @(negedge core_clk);
    send_raw(10'd100, 10'd50, 10'd80);
    repeat (30) @(negedge core_clk);
    chk_bit(i_host.got.size() == 0, 1'b1, "byte taken while stalled");
    hold = 1'b0;
    expect_report(10'd100, 10'd50, 10'd80);
    expect_report(10'd100, 10'd50, 10'd80);
    cfg.pressure_en = 1'b0;
    send_raw(10'd100, 10'd50, 10'd80);
    expect_report(10'd100, 10'd50, 10'd80);
    expect_quiet("fifth byte without pressure");
    cfg.pressure_en = 1'b1;
  endtask
  task automatic t_shutdown;
    int f;
    f = n_flush;
    touch_pin = 1'b0;
    i_host.send(touch_pkg::CMD_SHUTDOWN);
    expect_byte(touch_pkg::REPLY_ACK, "shutdown ack");
    wait_led(1'b1, 20);
    touch_pin = 1'b1;
    wait_led(1'b0, 10);
    chk_bit(n_flush == f + 1, 1'b1, "flush on touch wake");
    toggle(1'b0);
    i_host.send(touch_pkg::CMD_SHUTDOWN);
    expect_byte(touch_pkg::REPLY_ACK, "shutdown ack");
    wait_led(1'b1, 20);
    repeat (20) @(negedge core_clk);
    chk_bit(led_out, 1'b1, "touch woke commanded standby");
    i_host.send(touch_pkg::CMD_WAKE);
    wait_led(1'b0, 10);
    chk_bit(n_flush == f + 2, 1'b1, "flush on wake command");
    toggle(1'b1);
  endtask
  task automatic t_focus;
    cfg.focus = 6'h04;
    send_raw(10'd200, 10'd50, 10'd80);
    expect_report(10'd200, 10'd50, 10'd80);
    send_raw(10'd202, 10'd50, 10'd80);
    expect_report(10'd200, 10'd50, 10'd80);
    send_raw(10'd206, 10'd50, 10'd80);
    expect_report(10'd206, 10'd50, 10'd80);
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    chk_bit(spd_enabled, 1'b1, "self power-down default");
    wait_led(1'b0, 1);
    t_self();
    toggle(1'b0);
    toggle(1'b1);
    t_oversample();
    t_delta();
    t_pin();
    t_fifo();
    t_shutdown();
    t_focus();
    wrap_up();
  end
  // Whole sequence needs about 11000 cycles, most of it the wake delay
  initial begin
    repeat (40000) @(posedge core_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule // touch_power_filter_tb
